//--- tb/cts_capture_ctrl2_sva.sv
/* port checks for cts_capture_ctrl2, bound below.
   assumes events and timer_tick are one-cycle pulses on clk_sys. */
`default_nettype none
module cts_capture_ctrl2_sva import cts_pkg::*; (
    // clock, reset, apb
    input wire logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr,
    input wire logic [ADDR_W-1:0] paddr,
    // events
    input wire logic [4:0] timer_evt,
    input wire logic [3:0] capture_evt, compare_evt, sequencer_trigger_output,
    input wire logic [2:0] comparator_evt,
    input wire logic converter_evt, charge_time_evt, timer_tick, partner_cascade_enable,
    // status
    input wire logic [31:0] capture_timer,
    input wire logic trigger_status, cascade_enable, cascade_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic any_evt;
    logic done;
    // any event at all is excluded: cheaper than decoding the select here
    assign any_evt = |{timer_evt, capture_evt, compare_evt, comparator_evt, converter_evt, charge_time_evt,
        sequencer_trigger_output};
    assign done = psel && penable && pready;
    property p_hold; !trigger_status |=> capture_timer == 0; endproperty
    property p_count; trigger_status && timer_tick && !any_evt && capture_timer[15:0] != 16'hffff
        |=> capture_timer == $past(capture_timer) + 1; endproperty
    property p_still; trigger_status && !timer_tick && !any_evt |=> $stable(capture_timer); endproperty
    property p_sticky; trigger_status && !(done && pwrite) |=> trigger_status; endproperty
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    property p_err; done && paddr != 12'h000 && paddr != 12'h004 |-> pslverr; endproperty
    property p_casc; !partner_cascade_enable |=> !cascade_active; endproperty
    property p_casc2; !cascade_enable [*2] |-> !cascade_active; endproperty
    a_hold: assert property (p_hold) else $error("timer not held");
    a_count: assert property (p_count) else $error("timer miscount");
    a_still: assert property (p_still) else $error("timer moved");
    a_sticky: assert property (p_sticky) else $error("status lost");
    a_rdy: assert property (p_rdy) else $error("no ready");
    a_err: assert property (p_err) else $error("no error");
    a_casc: assert property (p_casc) else $error("cascade alone");
    a_casc2: assert property (p_casc2) else $error("cascade off");
    c_count: cover property (trigger_status && timer_tick);
    c_casc: cover property (cascade_active);
    c_err: cover property (done && pslverr);
endmodule // cts_capture_ctrl2_sva
bind cts_capture_ctrl2 cts_capture_ctrl2_sva cts_capture_ctrl2_sva_inst (.*);
`default_nettype wire

//--- tb/cts_capture_ctrl2_tb.sv
/* bench for cts_capture_ctrl2: apb accesses, source pulses, timer checks.
   assumes the design answers every apb access by itself. */
`default_nettype none
module cts_capture_ctrl2_tb import cts_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, timer_tick = 0;
    logic partner_cascade_enable = 0, pready, pslverr, trigger_status, cascade_enable, cascade_active;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, capture_timer, fire = '0, evt;
    int errors = 0, n_tests = 0, cyc = 0;
    cts_src_model cts_src_model_inst (.clk_sys(clk_sys), .fire(fire), .evt(evt));
    cts_capture_ctrl2 #(.CHANNEL_ID(0)) cts_capture_ctrl2_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_evt(evt[15:11]), .capture_evt(evt[19:16]),
        .compare_evt(evt[4:1]), .comparator_evt(evt[26:24]), .converter_evt(evt[27]),
        .charge_time_evt(evt[28]), .sequencer_trigger_output({evt[7:5], evt[10]}), .timer_tick(timer_tick),
        .partner_cascade_enable(partner_cascade_enable), .capture_timer(capture_timer),
        .trigger_status(trigger_status), .cascade_enable(cascade_enable), .cascade_active(cascade_active));
    initial forever #5 clk_sys = ~clk_sys;
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
        input logic err);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        if (!w) chk(prdata, exp);
        chk(pslverr, err);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic fire1(input logic [31:0] m);
        @(posedge clk_sys);
        fire <= m;
        @(posedge clk_sys);
        fire <= '0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic burst(input logic [31:0] t0);
        fire1(32'h800);
        chk(capture_timer, t0);
        repeat (3) @(posedge clk_sys);
        #1 chk(capture_timer, t0 + 3);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 80000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1;
        xfer(0, CTRL2_OFFSET, 0, CTRL2_RESET, 0);
        xfer(0, TIMER_OFFSET, 0, 0, 0);
        xfer(1, 12'h008, 32'hffff_ffff, 0, 1);
        xfer(1, CTRL2_OFFSET, 32'hffff_ffff, 0, 0);
        xfer(0, CTRL2_OFFSET, 0, 32'h1df, 0);
        chk(cascade_enable, 1);
        xfer(1, CTRL2_OFFSET, 0, 0, 0);
        xfer(0, CTRL2_OFFSET, 0, 0, 0);
        $display("register test done");
        for (int c = 0; c < 32; c++) begin
            if (c == 16) continue;
            xfer(1, CTRL2_OFFSET, 32'h80 | c, 0, 0);
            fire1(~(32'h1 << c));
            chk(trigger_status, 0);
            fire1(32'h1 << c);
            chk(trigger_status, c inside {[1:4], [10:19], [24:28]});
        end
        $display("source test done");
        timer_tick <= 1;
        xfer(1, CTRL2_OFFSET, 32'h8b, 0, 0);
        burst(0);
        burst(6);
        partner_cascade_enable <= 1;
        xfer(1, CTRL2_OFFSET, 32'h14b, 0, 0);
        burst(0);
        repeat (65533) @(posedge clk_sys);
        #1 chk(capture_timer, 32'h1_0000);
        chk(cascade_active, 1);
        $display("timer test done");
        report_and_stop();
    end
endmodule // cts_capture_ctrl2_tb
`default_nettype wire

//--- tb/cts_src_model.sv
/* source-block stand-in: each set bit of fire becomes an event a cycle later, held for as many cycles as fire is.
   assumes the caller drives fire just after a clk_sys edge. */
`default_nettype none
module cts_src_model (
    // clock
    input wire logic clk_sys,
    // pulse requests and events
    input wire logic [31:0] fire,
    output var logic [31:0] evt = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    // events last as long as fire is held; only the caller keeps them to one cycle
    always @(posedge clk_sys) evt <= fire;
endmodule // cts_src_model
`default_nettype wire

//--- verilog/cts_capture_ctrl2.sv
/*
 * Capture channel second control register with its capture timer:
 * trigger/sync source selection, trigger status, odd/even cascade.
 * Assumes APB master on clk_sys; source events and timer_tick are
 * one-cycle pulses from logic on clk_sys; partner cascade bit comes
 * from the paired channel's register on the same clock.
 */
// Design decisions made here: the APB interface to the registers and the address map.
`default_nettype none
module cts_capture_ctrl2
    import cts_pkg::*;
#(
    parameter int CHANNEL_ID = 0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // source events
    input wire logic [4:0] timer_evt,
    input wire logic [3:0] capture_evt,
    input wire logic [3:0] compare_evt,
    input wire logic [2:0] comparator_evt,
    input wire logic converter_evt,
    input wire logic charge_time_evt,
    input wire logic [3:0] sequencer_trigger_output,
    // capture timebase and cascade pairing
    input wire logic timer_tick,
    input wire logic partner_cascade_enable,
    // status toward the capture logic
    output logic [31:0] capture_timer,
    output logic trigger_status,
    output logic cascade_enable,
    output logic cascade_active
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic cascade;
        logic cascade_act;
        logic trig_sel;
        logic trig_stat;
        logic [4:0] source_sel;
        logic [31:0] timer;
    } cts_state_type;

    cts_state_type s_q;
    cts_state_type s_d;
    logic access;
    logic done;
    logic [15:0] ctrl2_view;

    cts_src_if src_bus ();

    assign src_bus.source_select = s_q.source_sel;

    cts_source_mux #(
        .CHANNEL_ID(CHANNEL_ID)
    ) u_mux (
        .bus(src_bus.mux),
        .timer_evt(timer_evt),
        .capture_evt(capture_evt),
        .compare_evt(compare_evt),
        .comparator_evt(comparator_evt),
        .converter_evt(converter_evt),
        .charge_time_evt(charge_time_evt),
        .sequencer_trigger_output(sequencer_trigger_output)
    );

    assign access = psel && penable;
    assign done = access && s_q.pready;

    always_comb begin
        ctrl2_view = 16'h0000;
        ctrl2_view[CASCADE_BIT] = s_q.cascade;
        ctrl2_view[TRIG_SEL_BIT] = s_q.trig_sel;
        ctrl2_view[TRIG_STAT_BIT] = s_q.trig_stat;
        ctrl2_view[SRC_LSB +: SRC_W] = s_q.source_sel;
    end

    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        // one wait state: answer is prepared on the first access edge so
        // that prdata and pready both come straight from flops
        if (access && !s_q.pready) begin
            s_d.pready = 1'b1;
            if (paddr == CTRL2_OFFSET) begin
                s_d.prdata = {16'h0000, ctrl2_view};
            end else if (paddr == TIMER_OFFSET) begin
                s_d.prdata = s_q.timer;
            end else begin
                s_d.prdata = 32'h0000_0000;
                s_d.pslverr = 1'b1;
            end
        end
        if (done && pwrite && paddr == CTRL2_OFFSET) begin
            if (pstrb[0]) begin
                s_d.trig_sel = pwdata[TRIG_SEL_BIT];
                s_d.trig_stat = pwdata[TRIG_STAT_BIT];
                s_d.source_sel = pwdata[SRC_LSB +: SRC_W];
            end
            if (pstrb[1]) begin
                s_d.cascade = pwdata[CASCADE_BIT];
            end
        end
        // hardware set wins over a software clear in the same cycle
        if (src_bus.source_event) begin
            s_d.trig_stat = 1'b1;
        end
        // pairing needs both halves; own choice of the other half is trusted
        s_d.cascade_act = s_d.cascade && partner_cascade_enable;
        if (!s_q.trig_stat) begin
            s_d.timer = TIMER_RESET;
        end else if (!s_q.trig_sel && src_bus.source_event) begin
            s_d.timer = TIMER_RESET;
        end else if (timer_tick) begin
            // either mode: counts on timer_tick once trigger status is set, by the event or by a write
            if (s_q.cascade_act) begin
                s_d.timer = s_q.timer + 32'h0000_0001;
            end else begin
                s_d.timer = {16'h0000, s_q.timer[15:0] + 16'h0001};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q.pready <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.prdata <= 32'h0000_0000;
            s_q.cascade <= CTRL2_RESET[CASCADE_BIT];
            s_q.cascade_act <= 1'b0;
            s_q.trig_sel <= CTRL2_RESET[TRIG_SEL_BIT];
            s_q.trig_stat <= CTRL2_RESET[TRIG_STAT_BIT];
            s_q.source_sel <= SRC_RESET;
            s_q.timer <= TIMER_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign capture_timer = s_q.timer;
    assign trigger_status = s_q.trig_stat;
    assign cascade_enable = s_q.cascade;
    assign cascade_active = s_q.cascade_act;
endmodule : cts_capture_ctrl2
`default_nettype wire

//--- verilog/cts_pkg.sv
/*
 * Shared constants for the capture trigger/sync control block: register map,
 * field positions, reset values and trigger/sync source codes.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
`default_nettype none
package cts_pkg;
    localparam int ADDR_W = 12;
    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL2_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] TIMER_OFFSET = 12'h004;
    // capture_control_two field positions
    localparam int CASCADE_BIT = 8;
    localparam int TRIG_SEL_BIT = 7;
    localparam int TRIG_STAT_BIT = 6;
    localparam int SRC_LSB = 0;
    localparam int SRC_W = 5;
    // reset values
    localparam logic [15:0] CTRL2_RESET = 16'h000d;
    localparam logic [4:0] SRC_RESET = 5'h0d;
    localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
    // source select codes
    localparam logic [4:0] SRC_NONE_LO = 5'h00;
    localparam logic [4:0] SRC_COMPARE1 = 5'h01;
    localparam logic [4:0] SRC_SEQUENCER = 5'h0a;
    localparam logic [4:0] SRC_TIMER1 = 5'h0b;
    localparam logic [4:0] SRC_CAPTURE1 = 5'h10;
    localparam logic [4:0] SRC_COMPARATOR1 = 5'h18;
    localparam logic [4:0] SRC_CONVERTER = 5'h1b;
    localparam logic [4:0] SRC_CHARGE_TIME = 5'h1c;
    localparam logic [4:0] SRC_NONE_HI = 5'h1f;
endpackage : cts_pkg
`default_nettype wire

//--- verilog/cts_source_mux.sv
/*
 * Trigger/sync source multiplexer for one capture channel.
 * Assumes every source event is a one-cycle pulse from logic on clk_sys.
 */
`default_nettype none
module cts_source_mux
    import cts_pkg::*;
#(
    parameter int CHANNEL_ID = 0
) (
    // select and selected event
    cts_src_if.mux bus,
    // source events
    input wire logic [4:0] timer_evt,
    input wire logic [3:0] capture_evt,
    input wire logic [3:0] compare_evt,
    input wire logic [2:0] comparator_evt,
    input wire logic converter_evt,
    input wire logic charge_time_evt,
    input wire logic [3:0] sequencer_trigger_output
);
    localparam logic [1:0] SEQ_IDX = CHANNEL_ID[1:0];

    logic [31:0] ev;

    // codes left at zero (none, reserved) never fire
    always_comb begin
        ev = 32'h0000_0000;
        ev[SRC_COMPARE1 +: 4] = compare_evt;
        ev[SRC_SEQUENCER] = sequencer_trigger_output[SEQ_IDX];
        ev[SRC_TIMER1 +: 5] = timer_evt;
        ev[SRC_CAPTURE1 +: 4] = capture_evt;
        ev[SRC_COMPARATOR1 +: 3] = comparator_evt;
        ev[SRC_CONVERTER] = converter_evt;
        ev[SRC_CHARGE_TIME] = charge_time_evt;
        bus.source_event = ev[bus.source_select];
    end
endmodule : cts_source_mux
`default_nettype wire

//--- verilog/cts_src_if.sv
/*
 * Carries the source select code to the source multiplexer and the selected
 * event back to the control logic. Both ends run on the same clock.
 */
`default_nettype none
interface cts_src_if;
    logic [4:0] source_select;
    logic source_event;
    modport ctrl (output source_select, input source_event);
    modport mux (input source_select, output source_event);
endinterface : cts_src_if
`default_nettype wire
